// ### rtl/pvs_pkg.sv
// Notes on behaviour
// - master drives bit clock and frame sync; slave takes both as inputs
// - up to three full-duplex voice channels, at most 16 slots per frame
// - slot count per frame follows the selected port rate: 1, 2, 4, 8 or 16
// - a channel transmits and receives in the same slot
// - data output is high impedance in every slot without an active channel
// - data output released after the falling bit-clock edge in a slot's last bit
// - short or long frame sync selectable as master and as slave
// - short sync: one bit period high pulse per frame, on a rising edge
// - slave samples sync on falling edges; after a short sync the next rising edge starts slot 0 bit 0
// - long sync: three bit periods high, starting with the first bit of slot 0
// - narrowband: 13 sample bits per 16-bit word, position and order configurable
// - spare bits dropped on receive; sent as zeros, ones, sign or constant
// - reset format: 13-bit two's complement, left aligned, most significant bit first
// - wideband transparent mode carries encoded 16-bit words over the port
// - transparent wideband mode also works as slave
// - wideband codec mode carries linear 16-bit samples
// - multiplexed operation only allowed while in master operation
// - more multiplexed channels need a faster bit clock
// - mode changes only while stopped; restart uses the new setup
// - all settings are loadable by the host through the register port
// - two instances exist; pin ownership against the other audio port is selectable
package pvs_pkg;
	localparam int         PVS_ADDR_W      = 8;
	localparam logic [7:0] PVS_OFS_CTRL    = 8'h00;
	localparam logic [7:0] PVS_OFS_FMT     = 8'h04;
	localparam logic [7:0] PVS_OFS_SLOT    = 8'h08;
	localparam logic [7:0] PVS_OFS_CLKDIV  = 8'h0C;
	localparam logic [7:0] PVS_OFS_STATUS  = 8'h10;
	localparam logic [7:0] PVS_OFS_TX0     = 8'h20;
	localparam logic [7:0] PVS_OFS_RX0     = 8'h30;
	// control fields
	localparam int PVS_CTRL_EN      = 0;
	localparam int PVS_CTRL_MASTER  = 1;
	localparam int PVS_CTRL_LONG    = 2;
	localparam int PVS_CTRL_SLOTS   = 3;  // 3 bits, log2 of slots per frame
	localparam int PVS_CTRL_MODE    = 6;  // 2 bits
	localparam int PVS_CTRL_MUX     = 8;
	localparam int PVS_CTRL_OWN     = 9;
	// format fields, then the slot register field width
	localparam int PVS_FMT_POS      = 0;  // 2 bits, lowest bit of sample in word
	localparam int PVS_FMT_LSBF     = 2;
	localparam int PVS_FMT_FILL     = 3;  // 2 bits
	localparam int PVS_FMT_CONST    = 5;  // 3 bits
	localparam int PVS_SLOT_FLD_W   = 5;  // enable then 4-bit slot, per channel
	// reset values and the slot-count limit
	localparam logic [1:0]  PVS_POS_RST     = 2'h3;
	localparam logic [11:0] PVS_CLKDIV_RST  = 12'hF4;
	localparam logic [2:0]  PVS_SLOTS_MAX   = 3'h4;
	// framing figures
	localparam int         PVS_WORD_BITS   = 16;
	localparam int         PVS_SAMPLE_BITS = 13;
	localparam logic [7:0] PVS_LONG_BITS   = 8'h03;
	localparam int         PVS_CHANNELS    = 3;

	typedef enum logic [1:0] {
		PVS_MODE_NARROW = 2'h0,
		PVS_MODE_WBTRAN = 2'h1,
		PVS_MODE_WBCODEC = 2'h2
	} pvs_mode_t;

	typedef enum logic [1:0] {
		PVS_FILL_ZERO  = 2'h0,
		PVS_FILL_ONE   = 2'h1,
		PVS_FILL_SIGN  = 2'h2,
		PVS_FILL_CONST = 2'h3
	} pvs_fill_t;

	typedef struct packed {
		logic      own;
		logic      mux;
		pvs_mode_t mode;
		logic [2:0] slots_lg;
		logic      long_sync;
		logic      master;
		logic      en;
	} pvs_ctrl_t;

	typedef struct packed {
		logic [2:0] fill_const;
		pvs_fill_t  fill;
		logic       lsb_first;
		logic [1:0] pos;
	} pvs_fmt_t;
endpackage

// ### rtl/pvs_port.sv
`timescale 1ns/10ps
module pvs_port #(
	parameter int DIV_W = 12
) (
	// clock and reset
	input  wire logic                         clock_i,
	input  wire logic                         rst_i,
	// register port
	input  wire logic [pvs_pkg::PVS_ADDR_W-1:0] addr_i,
	input  wire logic [31:0]                  wdata_i,
	input  wire logic                         wr_i,
	input  wire logic                         rd_i,
	output logic [31:0]                       rdata_o,
	// bit clock pin
	input  wire logic                         bclk_i,
	output logic                              bclk_o,
	output logic                              bclk_oe_o,
	// frame sync pin
	input  wire logic                         fsync_i,
	output logic                              fsync_o,
	output logic                              fsync_oe_o,
	// serial data
	input  wire logic                         din_i,
	output logic                              dout_o,
	output logic                              dout_oe_o
);
	import pvs_pkg::*;

	if (DIV_W < 2 || DIV_W > 16) begin : g_chk
		$error("DIV_W must lie between 2 and 16");
	end

	pvs_ctrl_t         ctrl_q;
	pvs_fmt_t          fmt_q;
	logic [14:0]       slot_q;
	logic [DIV_W-1:0]  div_q;
	logic [15:0]       tx_q [PVS_CHANNELS];
	logic [15:0]       rx_q [PVS_CHANNELS];
	logic [2:0]        rx_new_q;
	logic [31:0]       rdata_q;

	logic              wr_ctrl;
	logic              rd_rx [PVS_CHANNELS];
	logic              wide;
	assign wr_ctrl = wr_i && addr_i == PVS_OFS_CTRL;
	assign wide    = ctrl_q.mode != PVS_MODE_NARROW;

	// every setting is loaded through this port
	// while running only the enable bit may change, so the host must stop first
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl_q <= '0;
		end else if (wr_ctrl) begin
			if (!ctrl_q.en) begin
				ctrl_q.en        <= wdata_i[PVS_CTRL_EN];
				ctrl_q.master    <= wdata_i[PVS_CTRL_MASTER];
				ctrl_q.long_sync <= wdata_i[PVS_CTRL_LONG];
				ctrl_q.slots_lg  <= (wdata_i[PVS_CTRL_SLOTS+:3] > PVS_SLOTS_MAX) ?
					PVS_SLOTS_MAX : wdata_i[PVS_CTRL_SLOTS+:3];
				ctrl_q.mode      <= pvs_mode_t'(wdata_i[PVS_CTRL_MODE+:2]);
				ctrl_q.mux       <= wdata_i[PVS_CTRL_MUX] & wdata_i[PVS_CTRL_MASTER];
				ctrl_q.own       <= wdata_i[PVS_CTRL_OWN];
			end else begin
				ctrl_q.en <= wdata_i[PVS_CTRL_EN];
			end
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			fmt_q  <= '{fill_const: 3'h0, fill: PVS_FILL_ZERO, lsb_first: 1'b0, pos: PVS_POS_RST};
			slot_q <= '0;
			div_q  <= DIV_W'(PVS_CLKDIV_RST);
		end else if (wr_i && !ctrl_q.en) begin
			if (addr_i == PVS_OFS_FMT)
				fmt_q <= pvs_fmt_t'(wdata_i[7:0]);
			if (addr_i == PVS_OFS_SLOT)
				slot_q <= wdata_i[14:0];
			if (addr_i == PVS_OFS_CLKDIV)
				div_q <= (wdata_i[DIV_W-1:0] == '0) ? DIV_W'(1) : wdata_i[DIV_W-1:0];
		end
	end

	// transmit samples may be refreshed while running; each is taken at its slot start
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < PVS_CHANNELS; i++)
				tx_q[i] <= '0;
		end else begin
			for (int i = 0; i < PVS_CHANNELS; i++)
				if (wr_i && addr_i == PVS_OFS_TX0 + 8'(4 * i))
					tx_q[i] <= wdata_i[15:0];
		end
	end

	// slave inputs: first stage feeds only the second
	logic bs1_q, bs2_q, bs3_q, fs1_q, fs2_q, di1_q, di2_q;
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			{bs1_q, bs2_q, bs3_q, fs1_q, fs2_q, di1_q, di2_q} <= '0;
		end else begin
			bs1_q <= bclk_i;
			bs2_q <= bs1_q;
			bs3_q <= bs2_q;
			fs1_q <= fsync_i;
			fs2_q <= fs1_q;
			di1_q <= din_i;
			di2_q <= di1_q;
		end
	end

	// master bit clock from a divider of the core clock
	logic [DIV_W-1:0] dcnt_q;
	logic             bclk_q, tick;
	assign tick = dcnt_q == div_q - DIV_W'(1);
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			dcnt_q <= '0;
			bclk_q <= 1'b0;
		end else if (!ctrl_q.en || !ctrl_q.master) begin
			dcnt_q <= '0;
			bclk_q <= 1'b0;
		end else if (tick) begin
			dcnt_q <= '0;
			bclk_q <= !bclk_q;
		end else begin
			dcnt_q <= dcnt_q + DIV_W'(1);
		end
	end

	logic rise_ev, fall_ev;
	always_comb begin
		if (ctrl_q.master) begin
			rise_ev = ctrl_q.en && tick && !bclk_q;
			fall_ev = ctrl_q.en && tick && bclk_q;
		end else begin
			rise_ev = ctrl_q.en && bs2_q && !bs3_q;
			fall_ev = ctrl_q.en && !bs2_q && bs3_q;
		end
	end

	// frame bit counter: slot in the upper nibble, bit in the lower
	logic [7:0] cnt_q, last, n_cnt;
	logic       locked_q, fs_prev_q;
	assign last  = 8'((PVS_WORD_BITS << ctrl_q.slots_lg) - 1);
	assign n_cnt = (cnt_q == last) ? 8'h00 : cnt_q + 8'h01;

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_q     <= '0;
			locked_q  <= 1'b0;
			fs_prev_q <= 1'b0;
		end else if (!ctrl_q.en) begin
			cnt_q     <= last;
			locked_q  <= 1'b0;
			fs_prev_q <= 1'b0;
		end else begin
			if (ctrl_q.master)
				locked_q <= 1'b1;
			if (rise_ev)
				cnt_q <= n_cnt;
			if (fall_ev && !ctrl_q.master) begin
				fs_prev_q <= fs2_q;
				if (!ctrl_q.long_sync && fs2_q) begin
					cnt_q    <= last;
					locked_q <= 1'b1;
				end else if (ctrl_q.long_sync && fs2_q && !fs_prev_q) begin
					cnt_q    <= 8'h00;
					locked_q <= 1'b1;
				end
			end
		end
	end

	// master frame sync changes on the rising bit-clock edge
	logic fsync_q;
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			fsync_q <= 1'b0;
		end else if (!ctrl_q.en || !ctrl_q.master) begin
			fsync_q <= 1'b0;
		end else if (rise_ev) begin
			if (ctrl_q.long_sync)
				fsync_q <= n_cnt < PVS_LONG_BITS;
			else
				fsync_q <= n_cnt == last;
		end
	end

	// slot owners; the lowest channel wins if two share a slot
	logic [2:0] hit_n, hit_c;
	always_comb begin
		for (int i = 0; i < PVS_CHANNELS; i++) begin
			hit_n[i] = slot_q[PVS_SLOT_FLD_W*i] && slot_q[PVS_SLOT_FLD_W*i+1+:4] == n_cnt[7:4]
				&& 8'(slot_q[PVS_SLOT_FLD_W*i+1+:4]) <= last[7:4];
			hit_c[i] = slot_q[PVS_SLOT_FLD_W*i] && slot_q[PVS_SLOT_FLD_W*i+1+:4] == cnt_q[7:4]
				&& 8'(slot_q[PVS_SLOT_FLD_W*i+1+:4]) <= last[7:4];
		end
	end

	logic [1:0] ch_n, ch_c;
	always_comb begin
		ch_n = hit_n[0] ? 2'd0 : (hit_n[1] ? 2'd1 : 2'd2);
		ch_c = hit_c[0] ? 2'd0 : (hit_c[1] ? 2'd1 : 2'd2);
	end

	function automatic logic [12:0] pvs_rev13(input logic [12:0] v);
		logic [12:0] r;
		for (int k = 0; k < PVS_SAMPLE_BITS; k++)
			r[k] = v[PVS_SAMPLE_BITS-1-k];
		return r;
	endfunction

	// narrowband packing: sample placed at pos, the three spare bits filled
	function automatic logic [15:0] pvs_pack(input logic [15:0] s, input pvs_fmt_t f, input logic w);
		logic [12:0] b;
		logic [15:0] fillw, mask;
		b     = f.lsb_first ? pvs_rev13(s[12:0]) : s[12:0];
		mask  = 16'(16'h1FFF << f.pos);
		unique case (f.fill)
			PVS_FILL_ZERO:  fillw = 16'h0000;
			PVS_FILL_ONE:   fillw = 16'hFFFF;
			PVS_FILL_SIGN:  fillw = {16{s[12]}};
			PVS_FILL_CONST: fillw = {f.fill_const, {13{1'b0}}} | 16'(f.fill_const);
		endcase
		if (w)
			return s;
		return (fillw & ~mask) | (16'(b) << f.pos);
	endfunction

	// receive unpacking: spare bits dropped, result sign extended
	function automatic logic [15:0] pvs_unpack(input logic [15:0] wd, input pvs_fmt_t f, input logic w);
		logic [12:0] b;
		logic [15:0] sh;
		sh = wd >> f.pos;
		b  = f.lsb_first ? pvs_rev13(sh[12:0]) : sh[12:0];
		if (w)
			return wd;
		return {{3{b[12]}}, b};
	endfunction

	// transmit: next bit presented at each rising edge, released after the last falling edge
	logic [15:0] txw_q;
	logic        dout_q, doe_q;
	logic [15:0] txnew;
	assign txnew = pvs_pack(tx_q[ch_n], fmt_q, wide);
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			txw_q  <= '0;
			dout_q <= 1'b0;
			doe_q  <= 1'b0;
		end else if (!ctrl_q.en || !ctrl_q.own) begin
			dout_q <= 1'b0;
			doe_q  <= 1'b0;
		end else if (rise_ev) begin
			if (hit_n != '0 && locked_q) begin
				doe_q <= 1'b1;
				if (n_cnt[3:0] == 4'h0) begin
					dout_q <= txnew[15];
					txw_q  <= {txnew[14:0], 1'b0};
				end else begin
					dout_q <= txw_q[15];
					txw_q  <= {txw_q[14:0], 1'b0};
				end
			end else begin
				doe_q <= 1'b0;
			end
		end else if (fall_ev && cnt_q[3:0] == 4'hF) begin
			doe_q <= 1'b0;
		end
	end

	// receive: sample on falling edges, word complete at the last bit of the slot
	logic [15:0] rsh_q;
	logic        rx_done;
	assign rx_done = fall_ev && locked_q && hit_c != '0 && cnt_q[3:0] == 4'hF;
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			rsh_q <= '0;
			for (int i = 0; i < PVS_CHANNELS; i++)
				rx_q[i] <= '0;
		end else if (fall_ev) begin
			rsh_q <= {rsh_q[14:0], di2_q};
			if (rx_done)
				rx_q[ch_c] <= pvs_unpack({rsh_q[14:0], di2_q}, fmt_q, wide);
		end
	end

	// new-sample flags: a set in the cycle of its clearing read wins
	always_comb begin
		for (int i = 0; i < PVS_CHANNELS; i++)
			rd_rx[i] = rd_i && addr_i == PVS_OFS_RX0 + 8'(4 * i);
	end
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			rx_new_q <= '0;
		end else begin
			for (int i = 0; i < PVS_CHANNELS; i++)
				if (rx_done && ch_c == 2'(i))
					rx_new_q[i] <= 1'b1;
				else if (rd_rx[i])
					rx_new_q[i] <= 1'b0;
		end
	end

	// read data valid in the cycle after the strobe; unmapped reads return zero
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_q <= '0;
		end else if (rd_i) begin
			unique case (addr_i)
				PVS_OFS_CTRL:   rdata_q <= 32'(ctrl_q.own) << PVS_CTRL_OWN | 32'(ctrl_q.mux) << PVS_CTRL_MUX
					| 32'(ctrl_q.mode) << PVS_CTRL_MODE | 32'(ctrl_q.slots_lg) << PVS_CTRL_SLOTS
					| 32'(ctrl_q.long_sync) << PVS_CTRL_LONG | 32'(ctrl_q.master) << PVS_CTRL_MASTER
					| 32'(ctrl_q.en);
				PVS_OFS_FMT:    rdata_q <= 32'(fmt_q);
				PVS_OFS_SLOT:   rdata_q <= 32'(slot_q);
				PVS_OFS_CLKDIV: rdata_q <= 32'(div_q);
				PVS_OFS_STATUS: rdata_q <= {24'h000000, cnt_q[7:4] == 4'h0, rx_new_q, 2'h0, locked_q, ctrl_q.en};
				PVS_OFS_TX0, PVS_OFS_TX0 + 8'h04, PVS_OFS_TX0 + 8'h08:
					rdata_q <= 32'(tx_q[addr_i[3:2]]);
				PVS_OFS_RX0, PVS_OFS_RX0 + 8'h04, PVS_OFS_RX0 + 8'h08:
					rdata_q <= 32'(rx_q[addr_i[3:2]]);
				default:        rdata_q <= 32'h00000000;
			endcase
		end else begin
			rdata_q <= 32'h00000000;
		end
	end

	// pin enables; the clock and sync lines stay driven low when a master is stopped
	logic bclk_oe_q, fsync_oe_q;
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			bclk_oe_q  <= 1'b0;
			fsync_oe_q <= 1'b0;
		end else begin
			bclk_oe_q  <= ctrl_q.own && ctrl_q.master;
			fsync_oe_q <= ctrl_q.own && ctrl_q.master;
		end
	end

	assign rdata_o    = rdata_q;
	assign bclk_o     = bclk_q;
	assign bclk_oe_o  = bclk_oe_q;
	assign fsync_o    = fsync_q;
	assign fsync_oe_o = fsync_oe_q;
	assign dout_o     = dout_q;
	assign dout_oe_o  = doe_q;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);

	sequence s_last_fall;
		fall_ev && cnt_q[3:0] == 4'hF && !rise_ev;
	endsequence

	sequence s_short_start;
		ctrl_q.master && !ctrl_q.long_sync && rise_ev && n_cnt == last;
	endsequence

	stop_release_a: assert property (!ctrl_q.en |=> !doe_q)
		else $error("data driven while stopped");
	clk_idle_a: assert property (ctrl_q.master && !ctrl_q.en |=> !bclk_q && !fsync_q)
		else $error("master clock or sync active while stopped");
	last_release_a: assert property ((ctrl_q.en && ctrl_q.own) and s_last_fall |=> !doe_q)
		else $error("data not released after last bit");
	unused_slot_a: assert property (ctrl_q.en && rise_ev && hit_n == '0 |=> !doe_q)
		else $error("data driven in unused slot");
	short_pulse_a: assert property (s_short_start ##1 ctrl_q.en |-> fsync_q ##1 fsync_q)
		else $error("short sync pulse wrong");
	short_drop_a: assert property (ctrl_q.master && !ctrl_q.long_sync && rise_ev && n_cnt == 8'h00 |=> !fsync_q)
		else $error("short sync longer than one bit");
	long_pulse_a: assert property (ctrl_q.master && ctrl_q.long_sync && rise_ev |=>
		fsync_q == ($past(n_cnt) < PVS_LONG_BITS)) else $error("long sync width wrong");
	cfg_freeze_a: assert property (ctrl_q.en && wr_ctrl && wdata_i[PVS_CTRL_EN] |=>
		$stable(ctrl_q.slots_lg) && $stable(ctrl_q.master) && $stable(ctrl_q.mode)) else $error("config changed while running");
	mux_master_a: assert property (ctrl_q.mux |-> ctrl_q.master)
		else $error("multiplexing without master");
	slave_align_a: assert property (!ctrl_q.master && !ctrl_q.long_sync && ctrl_q.en && fall_ev && fs2_q
		|=> cnt_q == $past(last)) else $error("slave short sync not aligned");
	slot_limit_a: assert property (ctrl_q.slots_lg <= PVS_SLOTS_MAX)
		else $error("slot count above sixteen");
endmodule

// ### verif/pvs_codec_model.sv
`timescale 1ns/10ps
module pvs_codec_model #(
	parameter int FRAME_BITS = 32
) (
	// bus pins as seen on the board
	input  wire logic        bclk_w_i,
	input  wire logic        fsync_w_i,
	input  wire logic        dout_i,
	input  wire logic        dout_oe_i,
	output logic             bclk_m_o,
	output logic             fsync_m_o,
	output logic             din_o,
	// setup from the bench
	input  wire logic        gen_i,
	input  wire logic        long_i,
	input  wire logic [15:0] word_i,
	// what the codec saw: its slot word, enable errors, sync width and frame count
	output logic [15:0]      word_o,
	output logic             bad_o,
	output int               width_o,
	output int               frames_o
);
	int          bit_n = 0;
	int          run_w = 0;
	logic        fs_q  = 1'b0;
	logic        bad_q = 1'b0;
	logic [15:0] cap   = 16'h0000;
	logic        oe_pre = 1'b0;

	// the enable is looked at late in the high phase, where master and slave timing have both settled
	always @(posedge bclk_w_i) begin
		#28;
		oe_pre = dout_oe_i;
	end

	// codec owns slot 1 of a two-slot frame; slot 0 belongs to nobody
	initial begin
		bclk_m_o  = 1'b0;
		fsync_m_o = 1'b0;
		din_o     = 1'b0;
		word_o    = 16'h0000;
		bad_o     = 1'b0;
		width_o   = 0;
		frames_o  = 0;
		#3;
		forever begin
			if (!gen_i) begin
				bclk_m_o  = 1'b0;
				fsync_m_o = 1'b0;
				wait (gen_i);
				#3;
			end
			for (int b = 0; b < FRAME_BITS; b++) begin
				bclk_m_o  = 1'b1;
				fsync_m_o = long_i ? (b < 3) : (b == FRAME_BITS - 1);
				#32;
				bclk_m_o = 1'b0;
				#32;
			end
		end
	end

	always @(negedge bclk_w_i) begin
		if (fsync_w_i && !fs_q)
			bit_n = long_i ? 0 : FRAME_BITS - 1;
		else
			bit_n = (bit_n + 1) % FRAME_BITS;
		fs_q = fsync_w_i;
		if (fsync_w_i)
			run_w = run_w + 1;
		else if (run_w > 0) begin
			width_o = run_w;
			run_w = 0;
		end
		if (bit_n >= 16) begin
			cap = {cap[14:0], dout_i};
			if (!oe_pre)
				bad_q = 1'b1;
		end else if (oe_pre)
			bad_q = 1'b1;
		if (bit_n == FRAME_BITS - 1) begin
			word_o   = cap;
			bad_o    = bad_q;
			bad_q    = 1'b0;
			frames_o = frames_o + 1;
		end
	end

	// outside its slot the line is not ours: show a changing level, never the last bit
	always @(posedge bclk_w_i) begin
		if ((bit_n + 1) % FRAME_BITS >= 16)
			din_o = word_i[15 - ((bit_n + 1) % 16)];
		else
			din_o = ~din_o;
	end
endmodule

// ### verif/testbench.sv
`timescale 1ns/10ps
module testbench;
	import pvs_pkg::*;

	logic        clock_i, rst_i, wr_i, rd_i, din_i;
	logic [7:0]  addr_i;
	logic [31:0] wdata_i, rdata_o;
	logic        bclk_o, bclk_oe_o, fsync_o, fsync_oe_o, dout_o, dout_oe_o;
	logic        bclk_m, fsync_m, gen, long_s, bad;
	logic [15:0] rxw, word;
	int          width, frames, mismatches, n_compared, cyc;
	wire         bclk_w  = bclk_oe_o ? bclk_o : bclk_m;
	wire         fsync_w = fsync_oe_o ? fsync_o : fsync_m;

	pvs_port u_dut (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .bclk_i(bclk_w), .bclk_o(bclk_o), .bclk_oe_o(bclk_oe_o),
		.fsync_i(fsync_w), .fsync_o(fsync_o), .fsync_oe_o(fsync_oe_o), .din_i(din_i), .dout_o(dout_o),
		.dout_oe_o(dout_oe_o));

	pvs_codec_model u_codec (.bclk_w_i(bclk_w), .fsync_w_i(fsync_w), .dout_i(dout_o), .dout_oe_i(dout_oe_o),
		.bclk_m_o(bclk_m), .fsync_m_o(fsync_m), .din_o(din_i), .gen_i(gen), .long_i(long_s), .word_i(rxw),
		.word_o(word), .bad_o(bad), .width_o(width), .frames_o(frames));

	initial begin
		clock_i = 1'b0;
		forever #4 clock_i = ~clock_i;
	end

	task automatic tally_and_finish();
		$display("compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// a hung handshake must still end in the report
	always @(posedge clock_i) begin
		cyc = cyc + 1;
		if (cyc == 30000) begin
			mismatches = mismatches + 1;
			tally_and_finish();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared = n_compared + 1;
		if (got !== exp) begin
			mismatches = mismatches + 1;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
		@(posedge clock_i);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] got;
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clock_i);
		rd_i <= 1'b0;
		#1 got = rdata_o;
		@(posedge clock_i);
		chk(got, exp);
	endtask

	// one port setup, a few frames through the codec, then a stop
	task automatic run_case(input logic m, input logic l, input pvs_mode_t md, input pvs_fill_t fl,
		input logic [15:0] tx, input logic [15:0] rx, input logic probe);
		pvs_ctrl_t   c;
		pvs_fmt_t    f;
		logic [15:0] exp;
		int          n0;
		c          = '0;
		c.own      = 1'b1;
		c.master   = m;
		c.long_sync = l;
		c.slots_lg = 3'h1;
		c.mode     = md;
		c.mux      = ~m;
		f          = '0;
		f.pos      = PVS_POS_RST;
		f.fill     = fl;
		f.fill_const = 3'h5;
		gen    <= ~m;
		long_s <= l;
		rxw    <= rx;
		wr(PVS_OFS_FMT, {24'h0, f});
		wr(PVS_OFS_SLOT, 32'h3);
		wr(PVS_OFS_CLKDIV, 32'h4);
		wr(PVS_OFS_TX0, {16'h0, tx});
		c.en = 1'b1;
		wr(PVS_OFS_CTRL, {22'h0, c});
		c.mux = 1'b0;
		rd_chk(PVS_OFS_CTRL, {22'h0, c});
		n0 = frames;
		for (int i = 0; i < 6000 && frames < n0 + 4; i++)
			@(posedge clock_i);
		chk({31'h0, frames >= n0 + 4}, 32'h1);
		case (fl)
			PVS_FILL_ZERO:  exp = {tx[12:0], 3'h0};
			PVS_FILL_ONE:   exp = {tx[12:0], 3'h7};
			PVS_FILL_SIGN:  exp = {tx[12:0], {3{tx[12]}}};
			default:        exp = {tx[12:0], 3'h5};
		endcase
		if (md != PVS_MODE_NARROW)
			exp = tx;
		chk({16'h0, word}, {16'h0, exp});
		chk({31'h0, bad}, 32'h0);
		chk(width, l ? 32'h3 : 32'h1);
		chk({30'h0, bclk_oe_o, fsync_oe_o}, {30'h0, m, m});
		if (probe) begin
			wr(PVS_OFS_FMT, 32'hFF);
			rd_chk(PVS_OFS_FMT, {24'h0, f});
			c.master = ~m;
			wr(PVS_OFS_CTRL, {22'h0, c});
			c.master = m;
			rd_chk(PVS_OFS_CTRL, {22'h0, c});
		end
		c.en = 1'b0;
		wr(PVS_OFS_CTRL, {22'h0, c});
		gen <= 1'b0;
		repeat (300) @(posedge clock_i);
		chk({29'h0, dout_oe_o, bclk_o, fsync_o}, 32'h0);
		rd_chk(PVS_OFS_STATUS, 32'h10);
		if (md == PVS_MODE_NARROW)
			rd_chk(PVS_OFS_RX0, {16'h0, {3{rx[15]}}, rx[15:3]});
		else
			rd_chk(PVS_OFS_RX0, {16'h0, rx});
		rd_chk(PVS_OFS_STATUS, 32'h0);
	endtask

	initial begin
		rst_i   = 1'b1;
		addr_i  = 8'h00;
		wdata_i = 32'h0;
		wr_i    = 1'b0;
		rd_i    = 1'b0;
		gen     = 1'b0;
		long_s  = 1'b0;
		rxw     = 16'h0;
		mismatches = 0;
		n_compared = 0;
		cyc     = 0;
		repeat (4) @(posedge clock_i);
		rst_i <= 1'b0;
		@(posedge clock_i);
		chk({29'h0, bclk_oe_o, fsync_oe_o, dout_oe_o}, 32'h0);
		rd_chk(PVS_OFS_CTRL, 32'h0);
		rd_chk(PVS_OFS_FMT, {30'h0, PVS_POS_RST});
		rd_chk(PVS_OFS_CLKDIV, {20'h0, PVS_CLKDIV_RST});
		rd_chk(8'hFC, 32'h0);
		run_case(1'b1, 1'b0, PVS_MODE_NARROW, PVS_FILL_ZERO, 16'h1ABC, 16'hA5C3, 1'b1);
		run_case(1'b1, 1'b1, PVS_MODE_NARROW, PVS_FILL_ONE, 16'h0ABC, 16'h3C5A, 1'b0);
		run_case(1'b1, 1'b0, PVS_MODE_NARROW, PVS_FILL_SIGN, 16'h1ABC, 16'h5A3C, 1'b0);
		run_case(1'b1, 1'b1, PVS_MODE_NARROW, PVS_FILL_CONST, 16'h0ABC, 16'hC3A5, 1'b0);
		run_case(1'b1, 1'b0, PVS_MODE_WBTRAN, PVS_FILL_ZERO, 16'hC35A, 16'h96E1, 1'b0);
		run_case(1'b0, 1'b0, PVS_MODE_WBCODEC, PVS_FILL_ZERO, 16'h5AC3, 16'h1E69, 1'b0);
		run_case(1'b0, 1'b1, PVS_MODE_WBTRAN, PVS_FILL_ZERO, 16'h7E81, 16'h8E17, 1'b0);
		run_case(1'b0, 1'b1, PVS_MODE_NARROW, PVS_FILL_ZERO, 16'h1ABC, 16'hF00F, 1'b0);
		tally_and_finish();
	end
endmodule
